// file: src/tccc_top.sv
`timescale 1ns/10ps
module tccc_top
  import tccc_pkg::*;
#(
  parameter int PW = 4
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        special_mode,
  input  wire logic [3:0]  compare_match,
  input  wire logic [3:0]  channel_pin_in,
  output logic      [3:0]  channel_pin_out,
  output logic      [3:0]  channel_pin_oe,
  output logic      [3:0]  compare_flag_set,
  output logic             counter_overflow_flag,
  output logic      [15:0] main_counter
);
  logic [3:0]  channel_is_compare;
  logic [3:0]  ch7_compare_mask;
  logic [3:0]  ch7_compare_data;
  logic [7:0]  action_sel;
  logic [1:0]  ctrl;
  logic [PW-1:0] divide_m1;
  logic [3:0]  force_pulse;
  logic [3:0]  next_pin;
  logic        tick;

  // control word as read back
  logic [31:0] ctrl_word;

  // byte address compare, shared by every register decode
  function automatic logic reg_at(input logic [11:0] addr, input logic [11:0] offs);
    reg_at = (addr == offs);
  endfunction

  // access phase and direction
  wire acc     = psel & penable;
  wire wr      = acc & pwrite;

  // register hits
  wire hit_m   = reg_at(paddr, TCCC_A_MODE);
  wire hit_f   = reg_at(paddr, TCCC_A_FORCE);
  wire hit_k   = reg_at(paddr, TCCC_A_MASK);
  wire hit_d   = reg_at(paddr, TCCC_A_DATA);
  wire hit_c   = reg_at(paddr, TCCC_A_CNT);
  wire hit_t   = reg_at(paddr, TCCC_A_CTRL);
  wire hit_a   = reg_at(paddr, TCCC_A_ACTION);
  wire hit_s   = reg_at(paddr, TCCC_A_STATUS);
  wire mapped  = hit_m | hit_f | hit_k | hit_d | hit_c | hit_t | hit_a | hit_s;

  // byte lanes and channel field of the write data
  wire lane0   = pstrb[0];
  wire lane1   = pstrb[1];
  wire [3:0] wch = pwdata[7:4];

  // control fields
  wire enable  = ctrl[TCCC_CTRL_EN];
  wire ffc     = ctrl[TCCC_CTRL_FFC];

  // per-register write strobes; low lane carries every 8-bit register
  wire wr_mode  = wr & lane0 & hit_m;
  wire wr_force = wr & lane0 & hit_f;
  wire wr_mask  = wr & lane0 & hit_k;
  wire wr_data  = wr & lane0 & hit_d;
  wire wr_ctrl  = wr & lane0 & hit_t;
  wire wr_act   = wr & lane0 & hit_a;
  wire wr_stat  = wr & lane0 & hit_s;

  // zero-wait slave, error only for unmapped access
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // channel mode select
  always_ff @(posedge clk) begin
    if (rst) begin
      channel_is_compare <= TCCC_REG_RST[7:4];
    end else if (wr_mode) begin
      channel_is_compare <= wch;
    end
  end

  // channel 7 mask
  always_ff @(posedge clk) begin
    if (rst) begin
      ch7_compare_mask <= TCCC_REG_RST[7:4];
    end else if (wr_mask) begin
      ch7_compare_mask <= wch;
    end
  end

  // channel 7 data
  always_ff @(posedge clk) begin
    if (rst) begin
      ch7_compare_data <= TCCC_REG_RST[7:4];
    end else if (wr_data) begin
      ch7_compare_data <= wch;
    end
  end

  // output action codes, two bits a channel
  always_ff @(posedge clk) begin
    if (rst) begin
      action_sel <= TCCC_REG_RST;
    end else if (wr_act) begin
      action_sel <= pwdata[7:0];
    end
  end

  // enable, fast clear and prescale divide
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl      <= TCCC_REG_RST[1:0];
      divide_m1 <= '0;
    end else if (wr_ctrl) begin
      ctrl      <= pwdata[1:0];
      divide_m1 <= pwdata[8 +: PW];
    end
  end

  // force bits are write-only strobes
  assign force_pulse = wr_force ? wch : 4'h0;

  tccc_prescaler #(.W(PW)) u_pre (
    .clk       (clk),
    .rst       (rst),
    .run       (enable),
    .divide_m1 (divide_m1),
    .tick      (tick)
  );

  // counter access terms
  wire cnt_wr  = wr & hit_c & (lane0 | lane1) & special_mode;
  wire cnt_acc = acc & hit_c;
  wire wrap    = tick & (main_counter == 16'hffff);

  // main counter
  always_ff @(posedge clk) begin
    if (rst) begin
      main_counter <= TCCC_CNT_RST;
    end else if (cnt_wr) begin
      // both lanes land together in one cycle
      main_counter <= {lane1 ? pwdata[15:8] : main_counter[15:8],
                       lane0 ? pwdata[7:0]  : main_counter[7:0]};
    end else if (tick) begin
      main_counter <= main_counter + 16'h0001;
    end
  end

  // overflow flag: set wins over fast clear
  always_ff @(posedge clk) begin
    if (rst) begin
      counter_overflow_flag <= 1'b0;
    end else if (wrap & ~cnt_wr) begin
      counter_overflow_flag <= 1'b1;
    end else if (ffc & cnt_acc) begin
      counter_overflow_flag <= 1'b0;
    end else if (wr_stat & pwdata[0]) begin
      counter_overflow_flag <= 1'b0;
    end
  end

  // apply an output action to one pin level
  function automatic logic act(input logic [1:0] a, input logic cur);
    case (tccc_act_t'(a))
      TCCC_ACT_TOGGLE: act = ~cur;
      TCCC_ACT_CLEAR:  act = 1'b0;
      TCCC_ACT_SET:    act = 1'b1;
      default:         act = cur;
    endcase
  endfunction

  // per-channel output decision
  wire ch7_fire = channel_is_compare[3] & (compare_match[3] | force_pulse[3]);
  genvar g;
  generate
    for (g = 0; g < TCCC_NCH; g++) begin : g_ch
      wire fire  = channel_is_compare[g] & (compare_match[g] | force_pulse[g]);
      wire owrd  = (g < 3) & ch7_fire & ch7_compare_mask[g] & channel_is_compare[g];
      wire ownpn = act(action_sel[2*g +: 2], channel_pin_out[g]);
      assign next_pin[g] = owrd ? ch7_compare_data[g]
                         : (fire ? ownpn : channel_pin_out[g]);
      // pin driven when compare with action, or with mask set on channels 6..4
      assign channel_pin_oe[g] = channel_is_compare[g] &
             ((action_sel[2*g +: 2] != 2'b00) |
              ((g < 3) & ch7_compare_mask[g]));
      // flags only from real compares without a force
      assign compare_flag_set[g] = channel_is_compare[g] & compare_match[g] &
                                   ~force_pulse[g];
    end
  endgenerate

  // channel 7 data also applies to itself when masked
  always_ff @(posedge clk) begin
    if (rst) begin
      channel_pin_out <= 4'h0;
    end else begin
      channel_pin_out <= (ch7_fire & ch7_compare_mask[3])
                         ? {ch7_compare_data[3], next_pin[2:0]} : next_pin;
    end
  end

  // control fields packed into one word
  always_comb begin
    ctrl_word             = 32'h0000_0000;
    ctrl_word[8 +: PW]    = divide_m1;
    ctrl_word[1:0]        = ctrl;
  end

  // read data per register, zero when not addressed
  wire [31:0] rd_mode = hit_m ? {24'h00_0000, channel_is_compare, 4'h0} : 32'h0000_0000;
  wire [31:0] rd_mask = hit_k ? {24'h00_0000, ch7_compare_mask, 4'h0} : 32'h0000_0000;
  wire [31:0] rd_data = hit_d ? {24'h00_0000, ch7_compare_data, 4'h0} : 32'h0000_0000;
  wire [31:0] rd_cnt  = hit_c ? {16'h0000, main_counter} : 32'h0000_0000;
  wire [31:0] rd_ctrl = hit_t ? ctrl_word : 32'h0000_0000;
  wire [31:0] rd_act  = hit_a ? {24'h00_0000, action_sel} : 32'h0000_0000;
  wire [31:0] rd_stat = hit_s ? {20'h0_0000, channel_pin_in, channel_pin_out, 3'b000,
                                 counter_overflow_flag} : 32'h0000_0000;

  // read mux; force register has no term and reads zero
  assign prdata = rd_mode | rd_mask | rd_data | rd_cnt |
                  rd_ctrl | rd_act | rd_stat;
endmodule // tccc_top

// file: src/tccc_pkg.sv
// Overview of operation
// - select bit: 0 capture, 1 compare
// - force register writable, always reads zero
// - force bit fires programmed compare action now
// - forced action never sets channel flag
// - channel 7 compare overrides masked compare channels 6..4
// - force beats coincident compare, no flag
// - mask bit drives pin in compare mode on channels 6..4 only
// - channel 7 compare copies data bits to port where the mask bit is set
// - 16-bit up counter cleared by reset
// - counter writable only in special mode
// - word access moves both bytes at once
// - counter write leaves prescaler running unchanged
// - global enable clear stops the counter
// - fast clear: counter access clears overflow flag
package tccc_pkg;
  localparam int          TCCC_NCH       = 4;
  localparam logic [11:0] TCCC_A_MODE    = 12'h000;
  localparam logic [11:0] TCCC_A_FORCE   = 12'h004;
  localparam logic [11:0] TCCC_A_MASK    = 12'h008;
  localparam logic [11:0] TCCC_A_DATA    = 12'h00c;
  localparam logic [11:0] TCCC_A_CNT     = 12'h010;
  localparam logic [11:0] TCCC_A_CTRL    = 12'h014;
  localparam logic [11:0] TCCC_A_ACTION  = 12'h018;
  localparam logic [11:0] TCCC_A_STATUS  = 12'h01c;
  localparam int          TCCC_CTRL_EN   = 0;
  localparam int          TCCC_CTRL_FFC  = 1;
  localparam int          TCCC_CH_LSB    = 4;
  localparam logic [15:0] TCCC_CNT_RST   = 16'h0000;
  localparam logic [7:0]  TCCC_REG_RST   = 8'h00;
  localparam logic [3:0]  TCCC_PRE_RST   = 4'h0;
  // output action encoding held by the action register, two bits a channel
  typedef enum logic [1:0] {
    TCCC_ACT_NONE   = 2'b00,
    TCCC_ACT_TOGGLE = 2'b01,
    TCCC_ACT_CLEAR  = 2'b10,
    TCCC_ACT_SET    = 2'b11
  } tccc_act_t;
endpackage

// file: src/tccc_prescaler.sv
`timescale 1ns/10ps
module tccc_prescaler
  import tccc_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         run,
  input  wire logic [W-1:0] divide_m1,
  output logic              tick
);
  logic [W-1:0] count;
  wire          wrap = (count >= divide_m1);

  // free divider, unaffected by counter writes
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= W'(TCCC_PRE_RST);
    end else if (run) begin
      count <= wrap ? '0 : count + 1'b1;
    end
  end

  assign tick = run & wrap;
endmodule // tccc_prescaler

// file: sim/tccc_asserts.sv
`timescale 1ns/10ps
module tccc_asserts
  import tccc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        special_mode,
  input wire logic [3:0]  compare_match,
  input wire logic [3:0]  compare_flag_set,
  input wire logic        counter_overflow_flag,
  input wire logic [15:0] main_counter
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // access-phase decodes
  wire acc = psel && penable;
  wire cw  = acc && pwrite && paddr == TCCC_A_CNT && |pstrb[1:0];
  wire fw  = acc && pwrite && paddr == TCCC_A_FORCE && pstrb[0];
  // counter passes its top value, then zero
  sequence wrap_s;
    main_counter == 16'hffff ##1 !main_counter;
  endsequence
  frc_zero_a: assert property (acc && !pwrite && paddr == TCCC_A_FORCE |-> !prdata)
    else $error("force read not zero");
  cnt_clr_a: assert property (disable iff (1'b0) rst |=> !main_counter)
    else $error("counter not cleared");
  cnt_step_a: assert property ($changed(main_counter) && !$past(cw) |->
    main_counter == $past(main_counter) + 16'h0001) else $error("counter jumped");
  cnt_load_a: assert property (cw && &pstrb[1:0] && special_mode |=>
    main_counter == $past(pwdata[15:0])) else $error("word load lost");
  cnt_lock_a: assert property (cw && !special_mode |=>
    main_counter - $past(main_counter) <= 16'h0001) else $error("locked write taken");
  flag_hit_a: assert property (!(compare_flag_set & ~compare_match))
    else $error("flag without match");
  flag_frc_a: assert property (fw |-> !(compare_flag_set & pwdata[7:4]))
    else $error("flag on forced channel");
  ovf_wrap_a: assert property (wrap_s |-> counter_overflow_flag || $past(cw))
    else $error("wrap without overflow");
endmodule // tccc_asserts
bind tccc_top tccc_asserts chk (.*);

// file: sim/tccc_pin_model.sv
`timescale 1ns/10ps
module tccc_pin_model (
  input  wire logic       clk,
  input  wire logic [3:0] channel_pin_out,
  input  wire logic [3:0] channel_pin_oe,
  output logic      [3:0] channel_pin_in
);
  logic [3:0] ext = 4'h5;
  // undriven pins wander every cycle
  always @(posedge clk) ext <= ~ext;
  // driven pins read back the block's level
  assign channel_pin_in = (channel_pin_oe & channel_pin_out) | (~channel_pin_oe & ext);
endmodule // tccc_pin_model

// file: sim/timer_channel_compare_control_tb_top.sv
`timescale 1ns/10ps
module timer_channel_compare_control_tb_top import tccc_pkg::*;;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        special_mode = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hf;
  logic [3:0]  compare_match = 4'h0;
  logic [31:0] prdata, e;
  logic        pready, pslverr, counter_overflow_flag;
  logic [3:0]  channel_pin_in, channel_pin_out, channel_pin_oe, compare_flag_set;
  logic [15:0] main_counter, r;
  logic [31:0] q[$];
  integer      seed = 34, fails = 0, n_tests = 0, i;
  always #2 clk = ~clk;
  tccc_top dut (.*);
  tccc_pin_model pins (.*);
  task chk(input logic [15:0] g, input logic [15:0] x);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one transfer; a read leaves mask and expectation in the queue
  task apb(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [15:0] m);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    if (!w) q.push_back({m, d});
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d, 16'h0000);
  endtask
  // scoreboard on each completed read; error flag checked on every completed transfer
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = q.pop_front();
      chk(prdata[15:0] & e[31:16], e[15:0] & e[31:16]);
    end
    if (psel && penable && pready === 1'b1) begin
      chk({15'h0000, pslverr}, {15'h0000, paddr > TCCC_A_STATUS});
    end
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 5; i++) apb(1'b0, 12'(4 * i), 16'h0000, 16'hffff);
    r = 16'($random(seed));
    wr(TCCC_A_MODE, r & 16'h00f0);
    apb(1'b0, TCCC_A_MODE, r & 16'h00f0, 16'hffff);
    wr(TCCC_A_MODE, 16'h00f0);
    wr(TCCC_A_FORCE, 16'h00f0);
    apb(1'b0, TCCC_A_FORCE, 16'h0000, 16'hffff);
    for (i = 0; i < 4; i++) begin
      wr(TCCC_A_ACTION, 16'h00ff - 16'(i * 85));
      wr(TCCC_A_FORCE, 16'h00f0);
      apb(1'b0, TCCC_A_STATUS, (i == 1) ? 16'h0000 : 16'h00f0, 16'h00f0);
    end
    wr(TCCC_A_MASK, 16'h00f0);
    wr(TCCC_A_DATA, 16'h00a0);
    @(negedge clk) chk({12'h000, channel_pin_oe}, 16'h0007);
    @(posedge clk) compare_match <= 4'hf;
    @(negedge clk) chk({12'h000, compare_flag_set}, 16'h000f);
    @(posedge clk) compare_match <= 4'h0;
    apb(1'b0, TCCC_A_STATUS, 16'h00a0, 16'h00f0);
    wr(TCCC_A_CNT, 16'h1234);
    apb(1'b0, TCCC_A_CNT, 16'h0000, 16'hffff);
    special_mode <= 1'b1;
    wr(TCCC_A_CNT, r);
    apb(1'b0, TCCC_A_CNT, r, 16'hffff);
    wr(TCCC_A_CNT, 16'hfff0);
    wr(TCCC_A_CTRL, 16'h0001);
    repeat (40) @(posedge clk);
    wr(TCCC_A_CTRL, 16'h0002);
    apb(1'b0, TCCC_A_STATUS, 16'h0001, 16'h0001);
    apb(1'b0, TCCC_A_CNT, 16'h0000, 16'h0000);
    apb(1'b0, TCCC_A_STATUS, 16'h0000, 16'h0001);
    wr(TCCC_A_CNT, 16'h0005);
    repeat (10) @(posedge clk);
    apb(1'b0, TCCC_A_CNT, 16'h0005, 16'hffff);
    apb(1'b0, 12'h100, 16'h0000, 16'h0000);
    end_sim;
  end
  // watchdog
  initial begin
    #20000;
    fails++;
    end_sim;
  end
endmodule // timer_channel_compare_control_tb_top
